// ### dv/cdd_host.sv
// Host model driving the three-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module cdd_host (
	input wire logic clk_i, // Distribution clock
	output logic sclk_o, // Serial clock
	output logic sdata_o, // Serial data
	output logic slatch_o // Serial latch
);
	// ****
	// Word sender
	// ****
	initial begin
		sclk_o = 1'b0;
		sdata_o = 1'b0;
		slatch_o = 1'b0;
	end
	// Two clocks low and three clocks high per bit give margin over the edge detector
	task automatic send(input logic [31:0] w, input logic latch);
		for (int i = 31; i >= 0; i--) begin
			@(negedge clk_i) sdata_o = w[i];
			sclk_o = 1'b0;
			repeat (2) @(negedge clk_i);
			sclk_o = 1'b1;
			repeat (2) @(negedge clk_i);
		end
		@(negedge clk_i) sclk_o = 1'b0;
		sdata_o = 1'b0;
		slatch_o = latch;
		repeat (4) @(negedge clk_i);
		slatch_o = 1'b0;
	endtask
endmodule // cdd_host
`default_nettype wire

// ### dv/cdd_top_sva.sv
// Port checker for the distributor control block
`timescale 1ns/1ps
`default_nettype none
module cdd_top_sva (
	input wire logic clk_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic serial_latch_in_i, // Latch
	input wire logic global_enable_pin_i, // Enable pin
	input wire logic [7:0] channel_output_o, // Levels
	input wire logic [7:0] channel_off_o, // Off flags
	input wire logic [95:0] channel_delay_ps_o, // Delays
	input wire logic ref_select_o // Reference b
);
	// ****
	// Helpers
	// ****
	logic latch_r;
	logic [2:0] since_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Cycles since latch rise; saturates so old writes never wrap
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			latch_r <= 1'b0;
			since_r <= 3'h7;
		end else begin
			latch_r <= serial_latch_in_i;
			if (serial_latch_in_i && !latch_r)
				since_r <= 3'h0;
			else if (since_r != 3'h7)
				since_r <= since_r + 3'h1;
		end
	end
	// Every slice a whole step and inside the range
	function automatic logic dly_ok(input logic [95:0] v);
		dly_ok = 1'b1;
		for (int i = 0; i < 8; i++)
			if (v[i*12+:12] % 150 != 0 || v[i*12+:12] > 2250)
				dly_ok = 1'b0;
	endfunction
	// ****
	// Properties
	// ****
	a_boot_defaults: assert property ($rose(rst_n_i) |->
		(channel_off_o == 8'hFF && !ref_select_o)[*3])
		else $error("defaults lost after reset");
	a_pin_low_out: assert property ((!global_enable_pin_i)[*4] |->
		channel_output_o == 8'h00) else $error("pin low not held");
	a_off_out_low: assert property (
		(channel_output_o & channel_off_o & $past(channel_off_o)) == 8'h00)
		else $error("off channel drives high");
	a_delay_legal: assert property (dly_ok(channel_delay_ps_o))
		else $error("delay off step or range");
	a_cfg_hold: assert property ((!serial_latch_in_i)[*6] |->
		$stable(channel_delay_ps_o) && $stable(channel_off_o))
		else $error("config moved without latch");
	a_cfg_after_latch: assert property (
		$changed(channel_delay_ps_o) |-> since_r <= 3'h5)
		else $error("delay change not after latch");
	a_pin_not_off: assert property (
		$changed(global_enable_pin_i) && since_r == 3'h7 |=>
		$stable(channel_off_o)[*3]) else $error("pin changed off state");
	a_ref_after_latch: assert property (
		$changed(ref_select_o) |-> since_r <= 3'h5)
		else $error("reference moved without latch");
	c_ref_b: cover property ($rose(ref_select_o));
	c_pin_low: cover property ((!global_enable_pin_i)[*4]);
	c_enable: cover property ($fell(channel_off_o[3]));
endmodule // cdd_top_sva
bind cdd_top cdd_top_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.serial_latch_in_i(serial_latch_in_i),
	.global_enable_pin_i(global_enable_pin_i),
	.channel_output_o(channel_output_o), .channel_off_o(channel_off_o),
	.channel_delay_ps_o(channel_delay_ps_o), .ref_select_o(ref_select_o));
`default_nettype wire

// ### dv/clock_divider_distribution_test.sv
// Self-checking bench for the distributor control block
`timescale 1ns/1ps
`default_nettype none
module clock_divider_distribution_test;
	logic clk_i = 1'b0;
	logic ref_a = 1'b0;
	logic ref_b = 1'b0;
	logic rst_n_i, pin, align_n, sclk, sdata, slatch;
	wire [7:0] outs, offs;
	wire [95:0] dly;
	wire rsel;
	int n_fail, n_tests, k;
	cdd_host u_host (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata),
		.slatch_o(slatch));
	cdd_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .serial_clock_in_i(sclk),
		.serial_data_in_i(sdata), .serial_latch_in_i(slatch),
		.ref_input_a_i(ref_a), .ref_input_b_i(ref_b),
		.global_enable_pin_i(pin), .align_n_i(align_n),
		.channel_output_o(outs), .channel_off_o(offs),
		.channel_delay_ps_o(dly), .ref_select_o(rsel));
	// ****
	// Clock, references, helpers
	// ****
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Reference b runs at half the rate of a
	always @(negedge clk_i) begin
		ref_a <= ~ref_a;
		if (ref_a)
			ref_b <= ~ref_b;
	end
	task automatic chk(input string nm, input logic [11:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Toggles of channel 3 over eight cycles
	task automatic tog(input int exp);
		logic p;
		k = 0;
		p = outs[3];
		repeat (8) begin
			cyc(1);
			k += int'(outs[3] !== p);
			p = outs[3];
		end
		chk("tog3", 12'(k), 12'(exp));
	endtask
	function automatic logic [31:0] chw(input logic [3:0] a,
		input logic [1:0] mux, input logic [7:0] dv, input logic [3:0] dl);
		chw = {13'h0, mux, 1'b1, dv, dl, a};
	endfunction
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		{rst_n_i, align_n, pin} = 3'h3;
		n_fail = 0;
		n_tests = 0;
		cyc(12);
		rst_n_i = 1'b1;
		cyc(1);
		chk("off", 12'(offs), 12'h0FF);
		chk("rsel", 12'(rsel), 12'h000);
		u_host.send(chw(4'h3, 2'h0, 8'h01, 4'hF), 1'b1);
		cyc(3);
		chk("dly3", dly[47:36], 12'd2250);
		chk("dly2", dly[35:24], 12'd0);
		chk("off", 12'(offs), 12'h0F7);
		tog(8);
		pin = 1'b0;
		cyc(6);
		chk("out3", 12'(outs[3]), 12'h0);
		chk("off", 12'(offs), 12'h0F7);
		pin = 1'b1;
		$display("test enables done");
		u_host.send({2'h0, 1'b1, 1'b0, 1'b0, 27'h0E}, 1'b1);
		cyc(3);
		chk("off", 12'(offs), 12'h0FF);
		chk("rsel", 12'(rsel), 12'h001);
		u_host.send({2'h0, 1'b1, 1'b0, 1'b1, 27'h0E}, 1'b1);
		cyc(3);
		tog(4);
		u_host.send(chw(4'h0, 2'h2, 8'h01, 4'h2), 1'b1);
		u_host.send(chw(4'h9, 2'h1, 8'h04, 4'h5), 1'b1);
		cyc(3);
		chk("dly0", dly[11:0], 12'd300);
		chk("dly1", dly[23:12], 12'd0);
		chk("off", 12'(offs), 12'h0F6);
		u_host.send(chw(4'h3, 2'h0, 8'h01, 4'h1), 1'b0);
		cyc(6);
		u_host.send(32'hFFFFFFFF, 1'b1);
		cyc(3);
		chk("dly3", dly[47:36], 12'd2250);
		$display("test serial done");
		u_host.send(chw(4'h1, 2'h1, 8'h04, 4'h0), 1'b1);
		align_n = 1'b0;
		cyc(10);
		chk("out1", 12'(outs[1]), 12'h0);
		tog(4);
		align_n = 1'b1;
		for (k = 0; k < 40 && outs[1] !== 1'b1; k++)
			cyc(1);
		chk("align", 12'(k >= 4 && k <= 7), 12'h1);
		u_host.send(32'hFFFFFFF0, 1'b1);
		cyc(3);
		chk("dly3", dly[47:36], 12'd0);
		chk("rsel", 12'(rsel), 12'h000);
		chk("off", 12'(offs), 12'h0FF);
		$display("test align and reset done");
		report_and_stop();
	end
endmodule // clock_divider_distribution_test
`default_nettype wire

// ### rtl/cdd_channel.v
// One output channel: divider, alignment hold, delay code, gating
`timescale 1ns/1ps
`default_nettype none
`include "cdd_consts.vh"
module cdd_channel (
	input wire clk_i, // Distribution clock
	input wire rst_n_i, // Async reset, active low
	input wire ref_i, // Selected reference level
	input wire hold_i, // Aligned hold from align pin
	input wire [1:0] mux_i, // Channel source select
	input wire [7:0] div_i, // Channel divide value
	input wire [3:0] dly_i, // Channel delay code
	input wire en_i, // Combined enable
	input wire gate_low_i, // Enable pin forces low
	output reg out_o, // Channel output level
	output reg off_o, // Channel in Off state
	output reg [11:0] dly_ps_o // Delay in ps
);
	reg [7:0] cnt_r;
	reg div_r;
	wire divided;
	wire [7:0] half;
	assign divided = mux_i[0] | (div_i > 8'h01);
	assign half = (div_i == 8'h00) ? 8'h01 : div_i;

	// Divider restarts high together on release of the hold
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 8'h00;
			div_r <= 1'b0;
		end else if (hold_i) begin
			cnt_r <= 8'h00;
			div_r <= 1'b0;
		end else if (cnt_r == 8'h00) begin
			div_r <= ~div_r;
			cnt_r <= half - 8'h01;
		end else begin
			cnt_r <= cnt_r - 8'h01;
		end
	end

	// Output gating; bypass ignores hold and passes the reference
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_o <= 1'b0;
			off_o <= 1'b1;
			dly_ps_o <= 12'h000;
		end else begin
			off_o <= ~en_i;
			dly_ps_o <= {8'h00, dly_i} * 12'd`CDD_DLY_STEP_PS;
			if (!en_i || gate_low_i)
				out_o <= 1'b0;
			else if (mux_i == `CDD_MUX_BYPASS)
				out_o <= ref_i;
			else
				out_o <= divided ? div_r : ref_i;
		end
	end
endmodule // cdd_channel
`default_nettype wire

// ### rtl/cdd_consts.vh
// Constants for the clock divider distribution control block
`ifndef CDD_CONSTS_VH
`define CDD_CONSTS_VH

// ************************************************************
// Serial word layout
// ************************************************************
`define CDD_WORD_W 32
`define CDD_ADDR_W 4
`define CDD_DATA_W 28
`define CDD_NUM_CH 8

// ************************************************************
// Channel field positions inside words 0 to 7
// ************************************************************
`define CDD_F_RESET 31
`define CDD_F_MUX_HI 18
`define CDD_F_MUX_LO 17
`define CDD_F_EN 16
`define CDD_F_DIV_HI 15
`define CDD_F_DIV_LO 8
`define CDD_F_DLY_HI 7
`define CDD_F_DLY_LO 4

// ************************************************************
// Global word and field positions
// ************************************************************
`define CDD_ADDR_GLOBAL 4'hE
`define CDD_F_GEN 27
`define CDD_F_REFSEL 29

// ************************************************************
// Source select codes and reset values
// ************************************************************
`define CDD_MUX_BYPASS 2'h0
`define CDD_MUX_DIVIDED 2'h1
`define CDD_MUX_DELAYED 2'h2
`define CDD_MUX_DIVDLY 2'h3
`define CDD_RST_MUX 2'h0
`define CDD_RST_EN 1'h0
`define CDD_RST_DIV 8'h01
`define CDD_RST_DLY 4'h0
`define CDD_RST_GEN 1'h1
`define CDD_RST_REFSEL 1'h0

// ************************************************************
// Delay step and range, alignment latency
// ************************************************************
`define CDD_DLY_STEP_PS 150
`define CDD_DLY_MAX_PS 2250
`define CDD_SYNC_LAT 4
`endif

// ### rtl/cdd_top.v
// Control logic of the eight-channel clock distributor
`timescale 1ns/1ps
`default_nettype none
`include "cdd_consts.vh"
module cdd_top (
	input wire clk_i, // Distribution path clock
	input wire rst_n_i, // Power-on reset, active low
	input wire serial_clock_in_i, // Serial clock, synchronous level
	input wire serial_data_in_i, // Serial data
	input wire serial_latch_in_i, // Serial latch
	input wire ref_input_a_i, // Reference a level
	input wire ref_input_b_i, // Reference b level
	input wire global_enable_pin_i, // High or open enables
	input wire align_n_i, // Align pin, active low
	output wire [7:0] channel_output_o, // Channel output levels
	output wire [7:0] channel_off_o, // Channel Off state flags
	output wire [95:0] channel_delay_ps_o, // Delay ps, 12 bits each
	output reg ref_select_o // Reference in use, 1 is b
);
	// ************************************************************
	// Serial shift and latch
	// ************************************************************
	reg [31:0] shift_r;
	reg sclk_d_r;
	reg latch_d_r;
	reg [1:0] mux_r [0:7];
	reg en_r [0:7];
	reg [7:0] div_r [0:7];
	reg [3:0] dly_r [0:7];
	reg gen_r;
	wire sclk_rise;
	wire latch_rise;
	wire [3:0] addr;
	integer i;
	// Rise detectors; the pins idle low, so clearing the delayed
	// copies at reset cannot fake an edge straight after reset
	assign sclk_rise = serial_clock_in_i & ~sclk_d_r;
	assign latch_rise = serial_latch_in_i & ~latch_d_r;
	assign addr = shift_r[3:0];

	// Edge detect and shift; the pins are already synchronous
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_r <= 32'h0000_0000;
			sclk_d_r <= 1'b0;
			latch_d_r <= 1'b0;
		end else begin
			sclk_d_r <= serial_clock_in_i;
			latch_d_r <= serial_latch_in_i;
			if (sclk_rise)
				shift_r <= {shift_r[30:0], serial_data_in_i};
		end
	end

	// ************************************************************
	// Word decode
	// ************************************************************
	wire [2:0] chan_sel;
	wire word_reset;
	wire word_chan;
	wire word_global;
	wire [1:0] mux_f;
	wire en_f;
	wire [7:0] div_f;
	wire [3:0] dly_f;
	wire gen_f;
	wire refsel_f;
	// Reset word wins over a channel 0 write; its other bits are ignored
	assign chan_sel = addr[2:0];
	assign word_reset = latch_rise & (addr == 4'h0) &
		shift_r[`CDD_F_RESET];
	assign word_chan = latch_rise & ~word_reset & (addr < 4'h8);
	assign word_global = latch_rise & (addr == `CDD_ADDR_GLOBAL);
	// Field slices; addresses 8 to 13 and 15 select nothing
	assign mux_f = shift_r[`CDD_F_MUX_HI:`CDD_F_MUX_LO];
	assign en_f = shift_r[`CDD_F_EN];
	assign div_f = shift_r[`CDD_F_DIV_HI:`CDD_F_DIV_LO];
	assign dly_f = shift_r[`CDD_F_DLY_HI:`CDD_F_DLY_LO];
	assign gen_f = shift_r[`CDD_F_GEN];
	assign refsel_f = shift_r[`CDD_F_REFSEL];

	// ************************************************************
	// Register bank next values
	// ************************************************************
	reg [1:0] mux_nxt [0:7];
	reg en_nxt [0:7];
	reg [7:0] div_nxt [0:7];
	reg [3:0] dly_nxt [0:7];
	reg gen_nxt;
	reg ref_select_nxt;
	integer j;
	// Hold by default; only a decoded latch rise moves anything
	always @* begin
		gen_nxt = gen_r;
		ref_select_nxt = ref_select_o;
		for (j = 0; j < 8; j = j + 1) begin
			mux_nxt[j] = mux_r[j];
			en_nxt[j] = en_r[j];
			div_nxt[j] = div_r[j];
			dly_nxt[j] = dly_r[j];
		end
		if (word_reset) begin
			gen_nxt = `CDD_RST_GEN;
			ref_select_nxt = `CDD_RST_REFSEL;
			for (j = 0; j < 8; j = j + 1) begin
				mux_nxt[j] = `CDD_RST_MUX;
				en_nxt[j] = `CDD_RST_EN;
				div_nxt[j] = `CDD_RST_DIV;
				dly_nxt[j] = `CDD_RST_DLY;
			end
		end else if (word_chan) begin
			mux_nxt[chan_sel] = mux_f;
			en_nxt[chan_sel] = en_f;
			div_nxt[chan_sel] = div_f;
			dly_nxt[chan_sel] = dly_f;
		end else if (word_global) begin
			gen_nxt = gen_f;
			ref_select_nxt = refsel_f;
		end
	end

	// Bank flops; power-on reset loads the same defaults as the reset word
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gen_r <= `CDD_RST_GEN;
			ref_select_o <= `CDD_RST_REFSEL;
			for (i = 0; i < 8; i = i + 1) begin
				mux_r[i] <= `CDD_RST_MUX;
				en_r[i] <= `CDD_RST_EN;
				div_r[i] <= `CDD_RST_DIV;
				dly_r[i] <= `CDD_RST_DLY;
			end
		end else begin
			gen_r <= gen_nxt;
			ref_select_o <= ref_select_nxt;
			for (i = 0; i < 8; i = i + 1) begin
				mux_r[i] <= mux_nxt[i];
				en_r[i] <= en_nxt[i];
				div_r[i] <= div_nxt[i];
				dly_r[i] <= dly_nxt[i];
			end
		end
	end

	// ************************************************************
	// Alignment pipeline
	// ************************************************************
	reg align_q_r;
	reg [3:0] hold_pipe_r;
	wire hold_now;
	wire ref_sel;
	// Registered low then four more cycles; pull-up is outside pin
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			align_q_r <= 1'b0;
			hold_pipe_r <= 4'h0;
		end else begin
			align_q_r <= ~align_n_i;
			hold_pipe_r <= {hold_pipe_r[2:0], align_q_r};
		end
	end
	// Last stage releases every divider on the same edge, which is
	// what keeps the divided channels rising together
	assign hold_now = hold_pipe_r[`CDD_SYNC_LAT-1];

	// ************************************************************
	// Reference select
	// ************************************************************
	// One mux ahead of all channels, so bypassed and undivided delayed
	// channels share one source and stay in phase
	assign ref_sel = ref_select_o ? ref_input_b_i : ref_input_a_i;

	// ************************************************************
	// Channels
	// ************************************************************
	wire [7:0] chan_en;
	wire gate_low;
	// Pin low gives a low level, not Off, so off flags ignore it
	assign gate_low = ~global_enable_pin_i;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gen_ch
			// Channel bit and all-outputs bit both needed
			assign chan_en[g] = en_r[g] & gen_r;
			cdd_channel u_ch (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.ref_i(ref_sel),
				.hold_i(hold_now),
				.mux_i(mux_r[g]),
				.div_i(div_r[g]),
				.dly_i(dly_r[g]),
				.en_i(chan_en[g]),
				.gate_low_i(gate_low),
				.out_o(channel_output_o[g]),
				.off_o(channel_off_o[g]),
				.dly_ps_o(channel_delay_ps_o[g*12 +: 12])
			);
		end
	endgenerate
endmodule // cdd_top
`default_nettype wire
